// file: rtl/psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// Command codes of the register words.
`define PSC_CMD_CONF 8'h00
`define PSC_CMD_THR_LOW 8'h03
`define PSC_CMD_THR_HIGH 8'h04
`define PSC_CMD_FLAGS 8'hF9
// Bit positions inside the configuration word.
`define PSC_BIT_POWER 0
`define PSC_BIT_CAL 7
`define PSC_BIT_MODE_LO 8
`define PSC_BIT_PERS_LO 10
`define PSC_BIT_SMART 12
`define PSC_BIT_SUN 13
`define PSC_BIT_WIDE 14
// Bit positions of the event flags, high byte of the flag word.
`define PSC_FLAG_LOW 8
`define PSC_FLAG_HIGH 9
`define PSC_FLAG_SUN 12
// Reset values and the write mask.
`define PSC_CONF_RESET 16'h0000
`define PSC_THR_RESET 16'h0000
`define PSC_CONF_MASK 16'h7F81
// Interrupt mode codes.
`define PSC_MODE_OFF 2'h0
`define PSC_MODE_LEVEL 2'h1
`define PSC_MODE_EVENT 2'h3
`endif

// file: rtl/psc_pkg.sv
package psc_pkg;
	// One-hot states of the serial slave.
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RECV = 5'b00010,
		ST_ACK = 5'b00100,
		ST_SEND = 5'b01000,
		ST_RACK = 5'b10000
	} psc_state_e;
	// Layout of the configuration word.
	typedef struct packed {
		logic rsv15;
		logic wide_output_enable;
		logic sunlight_guard_irq_enable;
		logic adaptive_persistence_enable;
		logic [1:0] persistence_count;
		logic [1:0] irq_mode;
		logic calibration_enable;
		logic [5:0] rsv6_1;
		logic sensor_power_enable;
	} psc_conf_s;
	// One measurement from the front end.
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} psc_meas_s;
endpackage

// file: rtl/psc_top.sv
`timescale 1ns/100ps
`include "psc_defines.svh"
module psc_top #(
	parameter logic [6:0] SLAVE_ADDR = 7'h4C // Arbitrary value.
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SRST,
	// Serial bus pins.
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// Front end.
	input wire psc_pkg::psc_meas_s MEAS,
	input wire logic SUN_DET,
	output logic MEAS_WIDE,
	// Configuration seen by the front end.
	output logic POWER_ON,
	output logic CAL_EN,
	// Interrupt pin, active low.
	output logic INT_N
);
	import psc_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] scl_ff; // Stage 0 is read only by stage 1.
	logic [2:0] sda_ff;

	// Two flops bring the pins in; the third gives the previous level.
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			scl_ff <= 3'h7;
			sda_ff <= 3'h7;
		end
		else
		begin
			scl_ff <= {scl_ff[1:0], SCL_I};
			sda_ff <= {sda_ff[1:0], SDA_I};
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
	assign sda_now = sda_ff[1];
	assign scl_rise = scl_ff[1] & ~scl_ff[2];
	assign scl_fall = ~scl_ff[1] & scl_ff[2];
	// SDA moving while SCL is high marks start and stop.
	assign bus_start = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
	assign bus_stop = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];

	// ****************************************
	// Register file
	// ****************************************
	psc_conf_s conf_ff, nxt_conf; // Configuration word.
	logic [15:0] thr_low_ff, nxt_thr_low; // Low threshold.
	logic [15:0] thr_high_ff, nxt_thr_high; // High threshold.
	logic [15:0] flags_ff, nxt_flags; // Sticky event flags.
	logic [7:0] cmd_ff; // Command code of the transfer.
	logic wr_pulse_ff; // One byte arrived for the register file.
	logic [7:0] wr_byte_ff;
	logic wr_hi_ff; // Byte goes to the high half.
	logic rd_clr_ff; // High flag byte was read out.
	logic hi_evt, lo_evt, sun_evt;

	// Picks the byte returned for a command code.
	function automatic logic [7:0] rd_byte(input logic [7:0] cmd, input logic hi);
		logic [15:0] w;
		w = 16'h0000;
		case (cmd)
			`PSC_CMD_CONF: w = conf_ff;
			`PSC_CMD_THR_LOW: w = thr_low_ff;
			`PSC_CMD_THR_HIGH: w = thr_high_ff;
			`PSC_CMD_FLAGS: w = flags_ff;
			default: w = 16'h0000;
		endcase
		return hi ? w[15:8] : w[7:0];
	endfunction

	// Low byte then high byte; reserved bits are forced to zero on write.
	always_comb
	begin
		nxt_conf = conf_ff;
		nxt_thr_low = thr_low_ff;
		nxt_thr_high = thr_high_ff;
		nxt_flags = flags_ff;
		if (wr_pulse_ff)
		begin
			case (cmd_ff)
				`PSC_CMD_CONF:
				begin
					// Control bits take effect from the next edge.
					if (wr_hi_ff)
						nxt_conf[15:8] = wr_byte_ff & 8'(`PSC_CONF_MASK >> 8);
					else
						nxt_conf[7:0] = wr_byte_ff & 8'(`PSC_CONF_MASK);
				end
				`PSC_CMD_THR_LOW:
				begin
					if (wr_hi_ff)
						nxt_thr_low[15:8] = wr_byte_ff;
					else
						nxt_thr_low[7:0] = wr_byte_ff;
				end
				`PSC_CMD_THR_HIGH:
				begin
					if (wr_hi_ff)
						nxt_thr_high[15:8] = wr_byte_ff;
					else
						nxt_thr_high[7:0] = wr_byte_ff;
				end
				default:
				begin
					// Read-only or unmapped codes ignore writes.
				end
			endcase
		end
		// Reading clears the flags, but a new event in that cycle is kept.
		if (rd_clr_ff)
			nxt_flags = 16'h0000;
		if (hi_evt && conf_ff.irq_mode == `PSC_MODE_EVENT)
			nxt_flags[`PSC_FLAG_HIGH] = 1'b1;
		if (lo_evt && conf_ff.irq_mode == `PSC_MODE_EVENT)
			nxt_flags[`PSC_FLAG_LOW] = 1'b1;
		if (sun_evt)
			nxt_flags[`PSC_FLAG_SUN] = 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			conf_ff <= `PSC_CONF_RESET;
			thr_low_ff <= `PSC_THR_RESET;
			thr_high_ff <= `PSC_THR_RESET;
			flags_ff <= 16'h0000;
		end
		else
		begin
			conf_ff <= nxt_conf;
			thr_low_ff <= nxt_thr_low;
			thr_high_ff <= nxt_thr_high;
			flags_ff <= nxt_flags;
		end
	end

	// ****************************************
	// Serial slave
	// ****************************************
	psc_state_e st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt; // Bits moved in the current byte.
	logic [7:0] sh_ff, nxt_sh; // Shift register.
	logic addr_ph_ff, nxt_addr_ph; // Next byte is the address.
	logic cmd_ph_ff, nxt_cmd_ph; // Next byte is the command code.
	logic is_rd_ff, nxt_is_rd;
	logic hi_ff, nxt_hi; // Which half of the word comes next.
	logic oe_ff, nxt_oe;
	logic [7:0] nxt_cmd, nxt_wr_byte;
	logic nxt_wr_pulse, nxt_wr_hi, nxt_rd_clr;
	logic [7:0] tx;
	// A process rather than an assign, so a changed register word also refreshes the byte.
	always_comb
	begin
		tx = rd_byte(cmd_ff, hi_ff);
	end

	// A repeated start keeps the command code so a read follows it.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_addr_ph = addr_ph_ff;
		nxt_cmd_ph = cmd_ph_ff;
		nxt_is_rd = is_rd_ff;
		nxt_hi = hi_ff;
		nxt_oe = oe_ff;
		nxt_cmd = cmd_ff;
		nxt_wr_byte = wr_byte_ff;
		nxt_wr_hi = wr_hi_ff;
		nxt_wr_pulse = 1'b0;
		nxt_rd_clr = 1'b0;
		if (bus_start)
		begin
			// the command code survives every start, repeated or not, and every stop.
			nxt_st = ST_RECV;
			nxt_cnt = 4'h0;
			nxt_addr_ph = 1'b1;
			nxt_hi = 1'b0;
			nxt_oe = 1'b0;
		end
		else if (bus_stop)
		begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'b0;
		end
		else
		begin
			case (st_ff)
				ST_RECV:
				begin
					if (scl_rise)
					begin
						nxt_sh = {sh_ff[6:0], sda_now};
						nxt_cnt = cnt_ff + 4'h1;
					end
					else if (scl_fall && cnt_ff == 4'h8)
					begin
						nxt_cnt = 4'h0;
						nxt_st = ST_ACK;
						nxt_oe = 1'b1;
						if (addr_ph_ff)
						begin
							nxt_addr_ph = 1'b0;
							nxt_is_rd = sh_ff[0];
							nxt_cmd_ph = ~sh_ff[0];
							// Another address is not ours: stay off the bus.
							if (sh_ff[7:1] != SLAVE_ADDR)
							begin
								nxt_st = ST_IDLE;
								nxt_oe = 1'b0;
							end
						end
						else if (cmd_ph_ff)
						begin
							nxt_cmd_ph = 1'b0;
							nxt_cmd = sh_ff;
						end
						else
						begin
							nxt_wr_pulse = 1'b1;
							nxt_wr_byte = sh_ff;
							nxt_wr_hi = hi_ff;
							nxt_hi = ~hi_ff;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						if (is_rd_ff)
						begin
							nxt_st = ST_SEND;
							nxt_sh = tx;
							nxt_oe = ~tx[7];
							nxt_cnt = 4'h1;
						end
						else
						begin
							nxt_st = ST_RECV;
							nxt_oe = 1'b0;
						end
					end
				end
				ST_SEND:
				begin
					if (scl_fall)
					begin
						if (cnt_ff == 4'h8)
						begin
							nxt_st = ST_RACK;
							nxt_oe = 1'b0;
							nxt_rd_clr = hi_ff && cmd_ff == `PSC_CMD_FLAGS;
							nxt_hi = ~hi_ff;
						end
						else
						begin
							nxt_sh = {sh_ff[6:0], 1'b0};
							nxt_oe = ~sh_ff[6];
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				ST_RACK:
				begin
					// A not-acknowledge ends the read until the next start.
					if (scl_rise && sda_now)
						nxt_st = ST_IDLE;
					else if (scl_fall)
					begin
						nxt_st = ST_SEND;
						nxt_sh = tx;
						nxt_oe = ~tx[7];
						nxt_cnt = 4'h1;
					end
				end
				default:
				begin
					nxt_st = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			st_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			addr_ph_ff <= 1'b0;
			cmd_ph_ff <= 1'b0;
			is_rd_ff <= 1'b0;
			hi_ff <= 1'b0;
			oe_ff <= 1'b0;
			cmd_ff <= 8'h00;
			wr_byte_ff <= 8'h00;
			wr_hi_ff <= 1'b0;
			wr_pulse_ff <= 1'b0;
			rd_clr_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			addr_ph_ff <= nxt_addr_ph;
			cmd_ph_ff <= nxt_cmd_ph;
			is_rd_ff <= nxt_is_rd;
			hi_ff <= nxt_hi;
			oe_ff <= nxt_oe;
			cmd_ff <= nxt_cmd;
			wr_byte_ff <= nxt_wr_byte;
			wr_hi_ff <= nxt_wr_hi;
			wr_pulse_ff <= nxt_wr_pulse;
			rd_clr_ff <= nxt_rd_clr;
		end
	end

	// ****************************************
	// Threshold and interrupt logic
	// ****************************************
	logic [2:0] hi_cnt_ff, nxt_hi_cnt, lo_cnt_ff, nxt_lo_cnt; // Consecutive crossings.
	logic smart_hi_ff, nxt_smart_hi, smart_lo_ff, nxt_smart_lo; // Shortcut armed.
	logic lvl_ff, nxt_lvl; // Level-mode interrupt state.
	logic int_n_ff, nxt_int_n;
	logic sun_s1_ff, sun_s2_ff; // Sunlight detector from the analog side.
	logic [15:0] meas_used;
	logic above, below, take;
	logic [2:0] need_hi, need_lo;

	// In 12-bit mode the upper nibble is dropped.
	assign meas_used = conf_ff.wide_output_enable ? MEAS.data : {4'h0, MEAS.data[11:0]};
	assign take = MEAS.valid & conf_ff.sensor_power_enable;
	assign above = take & (meas_used > thr_high_ff);
	assign below = take & (meas_used < thr_low_ff);
	// Smart persistence drops to one measurement once an event fired.
	assign need_hi = smart_hi_ff ? 3'h1 : {1'b0, conf_ff.persistence_count} + 3'h1;
	assign need_lo = smart_lo_ff ? 3'h1 : {1'b0, conf_ff.persistence_count} + 3'h1;
	assign hi_evt = above && hi_cnt_ff + 3'h1 == need_hi;
	assign lo_evt = below && lo_cnt_ff + 3'h1 == need_lo;
	assign sun_evt = sun_s2_ff & conf_ff.sunlight_guard_irq_enable;

	// Counters restart after every event, so each later event qualifies anew.
	always_comb
	begin
		nxt_hi_cnt = 3'h0;
		nxt_lo_cnt = 3'h0;
		nxt_smart_hi = smart_hi_ff;
		nxt_smart_lo = smart_lo_ff;
		nxt_lvl = lvl_ff;
		if (!take)
		begin
			nxt_hi_cnt = hi_cnt_ff;
			nxt_lo_cnt = lo_cnt_ff;
		end
		else
		begin
			nxt_hi_cnt = (above && !hi_evt) ? hi_cnt_ff + 3'h1 : 3'h0;
			nxt_lo_cnt = (below && !lo_evt) ? lo_cnt_ff + 3'h1 : 3'h0;
			nxt_smart_hi = above & (smart_hi_ff | hi_evt) & conf_ff.adaptive_persistence_enable;
			nxt_smart_lo = below & (smart_lo_ff | lo_evt) & conf_ff.adaptive_persistence_enable;
		end
		if (!conf_ff.adaptive_persistence_enable)
		begin
			nxt_smart_hi = 1'b0;
			nxt_smart_lo = 1'b0;
		end
		if (conf_ff.irq_mode != `PSC_MODE_LEVEL)
			nxt_lvl = 1'b0;
		else if (hi_evt)
			nxt_lvl = 1'b1;
		else if (lo_evt)
			nxt_lvl = 1'b0;
		// Mode 10 and 00 both leave the pin released unless a sunlight flag with its guard enabled pulls it low.
		case (conf_ff.irq_mode)
			`PSC_MODE_LEVEL: nxt_int_n = ~lvl_ff;
			`PSC_MODE_EVENT: nxt_int_n = ~(flags_ff[`PSC_FLAG_HIGH] | flags_ff[`PSC_FLAG_LOW]);
			default: nxt_int_n = 1'b1;
		endcase
		if (flags_ff[`PSC_FLAG_SUN] && conf_ff.sunlight_guard_irq_enable)
			nxt_int_n = 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			hi_cnt_ff <= 3'h0;
			lo_cnt_ff <= 3'h0;
			smart_hi_ff <= 1'b0;
			smart_lo_ff <= 1'b0;
			lvl_ff <= 1'b0;
			int_n_ff <= 1'b1;
			sun_s1_ff <= 1'b0;
			sun_s2_ff <= 1'b0;
		end
		else
		begin
			hi_cnt_ff <= nxt_hi_cnt;
			lo_cnt_ff <= nxt_lo_cnt;
			smart_hi_ff <= nxt_smart_hi;
			smart_lo_ff <= nxt_smart_lo;
			lvl_ff <= nxt_lvl;
			int_n_ff <= nxt_int_n;
			sun_s1_ff <= SUN_DET;
			sun_s2_ff <= sun_s1_ff;
		end
	end

	// Outputs come from flops or, for SDA_O, a constant; the data line is only ever pulled low.
	assign SDA_O = 1'b0;
	assign SDA_OE = oe_ff;
	assign POWER_ON = conf_ff.sensor_power_enable;
	assign CAL_EN = conf_ff.calibration_enable;
	assign MEAS_WIDE = conf_ff.wide_output_enable;
	assign INT_N = int_n_ff;

	// ****************************************
	// Assertions
	// ****************************************
	sequence conf_lo_wr;
		wr_pulse_ff && !wr_hi_ff && cmd_ff == `PSC_CMD_CONF;
	endsequence
	sequence thr_hi_wr;
		wr_pulse_ff && wr_hi_ff && cmd_ff == `PSC_CMD_THR_LOW;
	endsequence

	cal_write_a: assert property (@(posedge CLK) disable iff (SRST)
		conf_lo_wr |=> CAL_EN == $past(wr_byte_ff[7]))
		else $error("Calibration bit not stored.");
	power_write_a: assert property (@(posedge CLK) disable iff (SRST)
		conf_lo_wr |=> POWER_ON == $past(wr_byte_ff[0]))
		else $error("Power bit not stored.");
	// Checked on the edge after each reset cycle, so no look back before time zero is needed.
	power_reset_a: assert property (@(posedge CLK)
		SRST |=> !POWER_ON && INT_N)
		else $error("Sensor not off after reset.");
	// A 12-bit sample under the high threshold must never count as above it.
	narrow_data_a: assert property (@(posedge CLK) disable iff (SRST)
		take && !MEAS_WIDE && MEAS.data[11:0] <= thr_high_ff |-> !above)
		else $error("Upper nibble used in 12-bit mode.");
	no_smart_a: assert property (@(posedge CLK) disable iff (SRST)
		!conf_ff.adaptive_persistence_enable ##1 !conf_ff.adaptive_persistence_enable
		|-> !smart_hi_ff)
		else $error("Smart persistence armed while off.");
	irq_off_a: assert property (@(posedge CLK) disable iff (SRST)
		(conf_ff.irq_mode[0] == 1'b0 && !conf_ff.sunlight_guard_irq_enable)[*2] |-> INT_N)
		else $error("Interrupt driven while disabled.");
	level_set_a: assert property (@(posedge CLK) disable iff (SRST)
		conf_ff.irq_mode == `PSC_MODE_LEVEL && hi_evt && !lo_evt
		##1 conf_ff.irq_mode == `PSC_MODE_LEVEL |=> !INT_N)
		else $error("Level interrupt not asserted.");
	event_flag_a: assert property (@(posedge CLK) disable iff (SRST)
		conf_ff.irq_mode == `PSC_MODE_EVENT && hi_evt |=> flags_ff[`PSC_FLAG_HIGH])
		else $error("High event lost.");
	persist_a: assert property (@(posedge CLK) disable iff (SRST)
		hi_evt && !smart_hi_ff |-> hi_cnt_ff == {1'b0, conf_ff.persistence_count})
		else $error("Event before enough crossings.");
	thr_store_a: assert property (@(posedge CLK) disable iff (SRST)
		thr_hi_wr |=> thr_low_ff[15:8] == $past(wr_byte_ff))
		else $error("Threshold byte not stored.");
endmodule

// file: tb/psc_host.sv
`timescale 1ns/100ps
// ****************************************
// Bus host model
// ****************************************
// Drives the serial clock and pulls the data line low; the pull-up lifts it otherwise.
module psc_host #(
	parameter logic [6:0] ADDR = 7'h4C // Arbitrary value.
) (
	// Bench clock.
	input wire logic clk,
	// Device pull-down enable.
	input wire logic sda_oe,
	// Resolved bus pins.
	output logic scl,
	output logic sda
);
	logic pull = 1'b0; // High while the host pulls the data line low.
	initial scl = 1'b1; // The serial clock rests high between frames.
	// A released line floats high through the pull-up, never at its last value.
	assign sda = !(pull || sda_oe);
	// One quarter of the serial clock period, two bench clocks.
	task automatic q();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Start, also used as the repeated start of a read.
	task automatic start();
		pull = 1'b0;
		q();
		scl = 1'b1;
		q();
		pull = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask
	// Stop ends every frame.
	task automatic stop();
		pull = 1'b1;
		q();
		scl = 1'b1;
		q();
		pull = 1'b0;
		q();
	endtask
	// Sends one bit; a one releases the line, so the same call also samples it.
	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
		q();
	endtask
	// Eight bits, most significant first, then the acknowledge slot.
	task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
	// Word write: command, then low byte, then high byte.
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, rx, a0);
		byte_io(cmd, 1'b1, rx, a1);
		byte_io(data[7:0], 1'b1, rx, a2);
		byte_io(data[15:8], 1'b1, rx, a3);
		stop();
		ok = !(a0 | a1 | a2 | a3);
	endtask
	// Word read; the last byte is refused so the device lets go of the line.
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, rx, a0);
		byte_io(cmd, 1'b1, rx, a1);
		start();
		byte_io({ADDR, 1'b1}, 1'b1, rx, a2);
		byte_io(8'hFF, 1'b0, data[7:0], a3);
		byte_io(8'hFF, 1'b1, data[15:8], a3);
		stop();
		ok = !(a0 | a1 | a2);
	endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import psc_pkg::*;
	logic clk = 1'b0; // Bench clock, 50 MHz.
	logic srst = 1'b1; // Held for two cycles at start.
	logic scl;
	logic sda;
	logic sda_oe;
	logic sda_o; // Open-drain data level, expected low at all times.
	psc_meas_s meas = '0; // Sample pulses from the front end.
	logic sun_det = 1'b0;
	logic meas_wide;
	logic power_on;
	logic cal_en;
	logic int_n;
	int err_total = 0;
	int compares = 0;
	logic [15:0] rd;
	logic ok;
	always #10 clk = !clk;
	psc_host i_psc_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	psc_top i_psc_top (.CLK(clk), .SRST(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .MEAS(meas), .SUN_DET(sun_det), .MEAS_WIDE(meas_wide),
		.POWER_ON(power_on), .CAL_EN(cal_en), .INT_N(int_n));
	// ****************************************
	// Shared tasks
	// ****************************************
	// Counts every compare; an unknown never passes for a match.
	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// The single place where the run ends.
	task automatic end_sim();
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reserved bits are always written as zero by these calls.
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		i_psc_host.write_word(cmd, d, ok);
		chk("write ack", {15'h0, ok}, 16'h0001);
	endtask
	task automatic rdchk(input string name, input logic [7:0] cmd, input logic [15:0] mask,
		input logic [15:0] exp);
		i_psc_host.read_word(cmd, rd, ok);
		chk("read ack", {15'h0, ok}, 16'h0001);
		chk(name, rd & mask, exp);
	endtask
	// Single-cycle sample pulses two cycles apart, then time for the pin to settle.
	task automatic sample(input logic [15:0] d, input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
			meas = {1'b1, d};
			@(posedge clk);
			#1;
			meas.valid = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic pin(input string name, input logic exp);
		chk(name, {15'h0, int_n}, {15'h0, exp});
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("outputs", {12'h0, power_on, cal_en, meas_wide, int_n}, 16'h0001);
		chk("sda idle", {14'h0, sda_oe, sda_o}, 16'h0000);
		rdchk("conf", 8'h00, 16'hFFFF, 16'h0000);
		wr(8'h00, 16'h0081);
		chk("power cal", {14'h0, power_on, cal_en}, 16'h0003);
		rdchk("conf", 8'h00, 16'hFFFF, 16'h0081);
		wr(8'h03, 16'h0100);
		wr(8'h04, 16'h0200);
		rdchk("thr low", 8'h03, 16'hFFFF, 16'h0100);
		rdchk("thr high", 8'h04, 16'hFFFF, 16'h0200);
		rdchk("unmapped", 8'h10, 16'hFFFF, 16'h0000);
		// Powered down, so the sample is not taken.
		wr(8'h00, 16'h0100);
		sample(16'h0300, 1);
		pin("off", 1'b1);
		wr(8'h00, 16'h0101);
		sample(16'h0300, 1);
		pin("lvl set", 1'b0);
		sample(16'h0150, 1);
		pin("lvl hold", 1'b0);
		sample(16'h0050, 1);
		pin("lvl clr", 1'b1);
		// Masked to 0x0FF in 12-bit mode, so it stays below.
		sample(16'hF0FF, 1);
		pin("narrow", 1'b1);
		wr(8'h00, 16'h4101);
		chk("wide", {15'h0, meas_wide}, 16'h0001);
		sample(16'hF0FF, 1);
		pin("wide", 1'b0);
		sample(16'h0050, 1);
		// The largest persistence code needs four crossings.
		wr(8'h00, 16'h0D01);
		sample(16'h0300, 3);
		pin("pers 3", 1'b1);
		sample(16'h0300, 1);
		pin("pers 4", 1'b0);
		wr(8'h00, 16'h0301);
		sample(16'h0300, 1);
		pin("evt high", 1'b0);
		rdchk("flag high", 8'hF9, 16'hFF00, 16'h0200);
		pin("evt clr", 1'b1);
		sample(16'h0050, 1);
		rdchk("flag low", 8'hF9, 16'hFF00, 16'h0100);
		wr(8'h00, 16'h0001);
		sample(16'h0300, 1);
		pin("mode 00", 1'b1);
		wr(8'h00, 16'h0201);
		sample(16'h0300, 1);
		pin("mode 10", 1'b1);
		// Without the adaptive scheme the next event would need four more samples.
		wr(8'h00, 16'h1F01);
		sample(16'h0300, 4);
		pin("smart 1st", 1'b0);
		rdchk("flag", 8'hF9, 16'hFF00, 16'h0200);
		sample(16'h0300, 1);
		pin("smart next", 1'b0);
		rdchk("flag", 8'hF9, 16'hFF00, 16'h0200);
		wr(8'h00, 16'h2001);
		sun_det = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		pin("sun", 1'b0);
		sun_det = 1'b0;
		rdchk("flag sun", 8'hF9, 16'hFF00, 16'h1000);
		pin("sun clr", 1'b1);
		end_sim();
	end
	// Watchdog well beyond the expected run of about 7,600 cycles.
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule
